// ==== rtl/cocs_map.svh ====
// Constants for the constant off-time chopper and its sync clock.
// Overview of operation
// [RULE1] Classic mode: comparator ends on phase, then fixed-length fast decay follows.
// [RULE2] Full-step load-dependent speed control forces classic mode regardless of mode select.
// [RULE3] Mode one: fast decay time is msb bit joined with start bits; zero means slow only.
// [RULE4] Fast decay time sets fast decay length per chopper cycle, each coil.
// [RULE5] Classic mode: end bits give offset, code 3 zero, below negative, above +1..+12.
// [RULE6] Comparator disable low ends fast decay on comparator; high ends it by time only.
// [RULE7] Without sync both coil choppers run independently.
// [RULE8] Random enable varies slow decay time pseudo-randomly; disabled gives fixed time.
// [RULE9] Sync lengthens off time to meet common sync clock, never shortens a cycle.
// [RULE10] Sync divider zero disables sync; 1..15 gives period of value times 64 clocks.
// [RULE11] Sync suspended while velocity exceeds the upper velocity limit.
// [RULE12] Sync has no effect while the quiet voltage-mode chopper runs.
// [RULE13] Software sets divider for twice chopper rate in mode zero, base rate in one.
// [RULE14] Software keeps slow decay short so each cycle ends before the next sync pulse.
// [RULE15] Mode select zero picks hysteresis chopper, one picks classic chopper.
// [RULE16] Classic mode adds the decoded offset to each coil target magnitude.
`ifndef COCS_MAP_SVH
`define COCS_MAP_SVH
`define COCS_OFF_BASE     10'd24
`define COCS_TIME_SHIFT   5
`define COCS_SYNC_SHIFT   6
`define COCS_OFFSET_ZERO  4'd3
`define COCS_LFSR_SEED    4'h1
`endif

// ==== rtl/cocs_pkg.sv ====
// Types shared by the chopper timing modules.
package cocs_pkg;
    typedef enum logic [2:0] {PH_IDLE, PH_ON, PH_FAST, PH_SLOW, PH_WAIT} cocs_phase_e;
endpackage : cocs_pkg

// ==== rtl/cocs_coil.sv ====
// One coil chopper: on, fast decay, slow decay and sync wait sequencing.
`timescale 1ns/1ps
`include "cocs_map.svh"
module cocs_coil
    import cocs_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        drv_en,
    input  wire logic        classic,
    input  wire logic [3:0]  fd_time,
    input  wire logic        fd_cmp_dis,
    input  wire logic [3:0]  off_time,
    input  wire logic [3:0]  rnd_add,
    input  wire logic        sync_en,
    input  wire logic        sync_pulse,
    input  wire logic        cur_reached,
    input  wire logic        fd_cmp_hit,
    output cocs_phase_e      phase
);
    cocs_phase_e phase_r, phase_nxt;
    logic [9:0]  cnt_r, cnt_nxt;
    logic [9:0]  slow_len;
    logic        fast_end;

    // Slow decay length; the random addend is already zero when modulation is off.
    assign slow_len = `COCS_OFF_BASE + {1'b0, off_time, 5'd0} + {6'd0, rnd_add}; // see [RULE8]
    // Hysteresis mode only ends fast decay on the comparator; classic ends on time or comparator.
    assign fast_end = classic ? ((cnt_r == 10'd1) || (!fd_cmp_dis && fd_cmp_hit)) // see [RULE6]
                              : fd_cmp_hit;

    always_comb
    begin
        phase_nxt = phase_r;
        cnt_nxt   = (cnt_r != 10'd0) ? cnt_r - 10'd1 : cnt_r;
        if (!drv_en)
            phase_nxt = PH_IDLE;
        else
        begin
            unique case (phase_r)
                PH_IDLE: phase_nxt = PH_ON;
                PH_ON:
                    if (cur_reached)
                    begin
                        if (classic && fd_time == 4'h0) // see [RULE3]
                        begin
                            phase_nxt = PH_SLOW;
                            cnt_nxt   = slow_len;
                        end
                        else
                        begin
                            phase_nxt = PH_FAST; // see [RULE1]
                            cnt_nxt   = {1'b0, fd_time, 5'd0}; // see [RULE4]
                        end
                    end
                PH_FAST:
                    if (fast_end)
                    begin
                        phase_nxt = PH_SLOW;
                        cnt_nxt   = slow_len;
                    end
                PH_SLOW:
                    if (cnt_r <= 10'd1)
                        phase_nxt = sync_en ? PH_WAIT : PH_ON; // see [RULE7] [RULE9]
                PH_WAIT:
                    if (sync_pulse || !sync_en)
                        phase_nxt = PH_ON;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            phase_r <= PH_IDLE;
            cnt_r   <= 10'd0;
        end
        else
        begin
            phase_r <= phase_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    assign phase = phase_r;

    sequence s_timed_fast_entry;
        phase_r == PH_ON && drv_en && classic && cur_reached && fd_time != 4'h0;
    endsequence

    a_fast_load: assert property (@(posedge clk) disable iff (sys_rst) // see [RULE4]
        s_timed_fast_entry |=> phase_r == PH_FAST && cnt_r == {1'b0, $past(fd_time), 5'd0})
        else $error("fast decay not loaded with programmed time");
    a_fast_cmp_end: assert property (@(posedge clk) disable iff (sys_rst) // see [RULE6]
        phase_r == PH_FAST && drv_en && classic && !fd_cmp_dis && fd_cmp_hit |=> phase_r == PH_SLOW)
        else $error("comparator did not end fast decay");
    a_fast_time_only: assert property (@(posedge clk) disable iff (sys_rst) // see [RULE6]
        phase_r == PH_FAST && drv_en && classic && fd_cmp_dis && cnt_r > 10'd1 |=> phase_r == PH_FAST)
        else $error("fast decay ended before its time");
    a_zero_fast: assert property (@(posedge clk) disable iff (sys_rst) // see [RULE3]
        phase_r == PH_ON && drv_en && classic && cur_reached && fd_time == 4'h0 |=> phase_r == PH_SLOW)
        else $error("zero fast decay time did not skip fast decay");
    a_sync_hold: assert property (@(posedge clk) disable iff (sys_rst) // see [RULE9]
        phase_r == PH_WAIT && drv_en && sync_en && !sync_pulse |=> phase_r == PH_WAIT)
        else $error("sync wait left without a sync pulse");
    a_free_run: assert property (@(posedge clk) disable iff (sys_rst) // see [RULE7]
        phase_r == PH_SLOW && drv_en && !sync_en && cnt_r == 10'd1 |=> phase_r == PH_ON)
        else $error("free running chopper did not restart");
endmodule : cocs_coil

// ==== rtl/cocs_top.sv ====
// Constant off-time chopper timing with random off time and common sync clock for two coils.
`timescale 1ns/1ps
`include "cocs_map.svh"
module cocs_top
    import cocs_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        chopper_mode,
    input  wire logic        fast_decay_msb,
    input  wire logic [2:0]  hysteresis_start_field,
    input  wire logic [3:0]  hysteresis_end_field,
    input  wire logic [3:0]  slow_decay_time,
    input  wire logic        fd_cmp_disable,
    input  wire logic        random_off_en,
    input  wire logic [3:0]  sync_divider,
    input  wire logic [19:0] velocity,
    input  wire logic [19:0] upper_velocity_limit,
    input  wire logic        full_step_active,
    input  wire logic        quiet_mode_active,
    input  wire logic [7:0]  target_mag_a,
    input  wire logic [7:0]  target_mag_b,
    input  wire logic        cur_reached_a,
    input  wire logic        cur_reached_b,
    input  wire logic        fd_cmp_a,
    input  wire logic        fd_cmp_b,
    output cocs_phase_e      phase_a,
    output cocs_phase_e      phase_b,
    output logic [8:0]       threshold_a,
    output logic [8:0]       threshold_b,
    output logic             classic_active,
    output logic             sync_active,
    output logic             sync_pulse
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Target magnitude plus signed offset (code minus three), clamped at zero.
    function automatic logic [8:0] cocs_offset_target(input logic [7:0] mag, input logic [3:0] code,
                                                      input logic en);
        logic signed [9:0] sum;
        sum = $signed({2'b00, mag}) + $signed({6'd0, code}) - $signed({6'd0, `COCS_OFFSET_ZERO});
        if (!en)
            cocs_offset_target = {1'b0, mag};
        else if (sum < 10'sd0)
            cocs_offset_target = 9'd0;
        else
            cocs_offset_target = sum[8:0];
    endfunction : cocs_offset_target

    // ------------------------------------------------------------
    // Comparator input synchronisers
    // ------------------------------------------------------------
    // Comparators are analogue and asynchronous; two stages guard against metastability.
    logic [3:0] cmp_meta_r, cmp_meta_nxt;
    logic [3:0] cmp_sync_r, cmp_sync_nxt;

    always_comb
    begin
        cmp_meta_nxt = {fd_cmp_b, fd_cmp_a, cur_reached_b, cur_reached_a};
        cmp_sync_nxt = cmp_meta_r;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            cmp_meta_r <= 4'h0;
            cmp_sync_r <= 4'h0;
        end
        else
        begin
            cmp_meta_r <= cmp_meta_nxt;
            cmp_sync_r <= cmp_sync_nxt;
        end
    end

    // ------------------------------------------------------------
    // Mode selection and current thresholds
    // ------------------------------------------------------------
    logic       classic_r, classic_nxt;
    logic [3:0] fd_time_r, fd_time_nxt;
    logic [8:0] thr_a_r, thr_a_nxt;
    logic [8:0] thr_b_r, thr_b_nxt;

    always_comb
    begin
        classic_nxt = chopper_mode || full_step_active; // see [RULE15] [RULE2]
        fd_time_nxt = {fast_decay_msb, hysteresis_start_field}; // see [RULE3]
        thr_a_nxt   = cocs_offset_target(target_mag_a, hysteresis_end_field, classic_r); // see [RULE5] [RULE16]
        thr_b_nxt   = cocs_offset_target(target_mag_b, hysteresis_end_field, classic_r); // see [RULE5] [RULE16]
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            classic_r <= 1'b0;
            fd_time_r <= 4'h0;
            thr_a_r   <= 9'd0;
            thr_b_r   <= 9'd0;
        end
        else
        begin
            classic_r <= classic_nxt;
            fd_time_r <= fd_time_nxt;
            thr_a_r   <= thr_a_nxt;
            thr_b_r   <= thr_b_nxt;
        end
    end

    // ------------------------------------------------------------
    // Random off-time generator
    // ------------------------------------------------------------
    // A four-bit maximal-length sequence is enough to smear the beat between coils.
    logic [3:0] lfsr_r, lfsr_nxt;
    logic [3:0] rnd_a_r, rnd_a_nxt;
    logic [3:0] rnd_b_r, rnd_b_nxt;

    always_comb
    begin
        lfsr_nxt  = {lfsr_r[2:0], lfsr_r[3] ^ lfsr_r[2]};
        rnd_a_nxt = random_off_en ? lfsr_r : 4'h0; // see [RULE8]
        rnd_b_nxt = random_off_en ? {lfsr_r[1:0], lfsr_r[3:2]} : 4'h0; // see [RULE8]
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            lfsr_r  <= `COCS_LFSR_SEED;
            rnd_a_r <= 4'h0;
            rnd_b_r <= 4'h0;
        end
        else
        begin
            lfsr_r  <= lfsr_nxt;
            rnd_a_r <= rnd_a_nxt;
            rnd_b_r <= rnd_b_nxt;
        end
    end

    // ------------------------------------------------------------
    // Sync clock divider
    // ------------------------------------------------------------
    logic [9:0] div_cnt_r, div_cnt_nxt;
    logic [9:0] div_period;
    logic       pulse_r, pulse_nxt;
    logic       sync_en_r, sync_en_nxt;

    assign div_period = {sync_divider, 6'd0};

    always_comb
    begin
        div_cnt_nxt = 10'd0;
        pulse_nxt   = 1'b0;
        if (sync_divider != 4'h0) // see [RULE10]
        begin
            if (div_cnt_r >= div_period - 10'd1)
                pulse_nxt = 1'b1;
            else
                div_cnt_nxt = div_cnt_r + 10'd1;
        end
        sync_en_nxt = (sync_divider != 4'h0) && (velocity <= upper_velocity_limit) // see [RULE11]
                      && !quiet_mode_active; // see [RULE12]
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            div_cnt_r <= 10'd0;
            pulse_r   <= 1'b0;
            sync_en_r <= 1'b0;
        end
        else
        begin
            div_cnt_r <= div_cnt_nxt;
            pulse_r   <= pulse_nxt;
            sync_en_r <= sync_en_nxt;
        end
    end

    // ------------------------------------------------------------
    // Coil choppers
    // ------------------------------------------------------------
    // Slow decay time zero keeps both bridges idle, as the driver is then disabled.
    cocs_coil u_coil_a (
        .clk         (clk),
        .sys_rst     (sys_rst),
        .drv_en      (slow_decay_time != 4'h0),
        .classic     (classic_r),
        .fd_time     (fd_time_r),
        .fd_cmp_dis  (fd_cmp_disable),
        .off_time    (slow_decay_time),
        .rnd_add     (rnd_a_r),
        .sync_en     (sync_en_r),
        .sync_pulse  (pulse_r),
        .cur_reached (cmp_sync_r[0]),
        .fd_cmp_hit  (cmp_sync_r[2]),
        .phase       (phase_a)
    );

    cocs_coil u_coil_b (
        .clk         (clk),
        .sys_rst     (sys_rst),
        .drv_en      (slow_decay_time != 4'h0),
        .classic     (classic_r),
        .fd_time     (fd_time_r),
        .fd_cmp_dis  (fd_cmp_disable),
        .off_time    (slow_decay_time),
        .rnd_add     (rnd_b_r),
        .sync_en     (sync_en_r),
        .sync_pulse  (pulse_r),
        .cur_reached (cmp_sync_r[1]),
        .fd_cmp_hit  (cmp_sync_r[3]),
        .phase       (phase_b)
    );

    assign threshold_a    = thr_a_r;
    assign threshold_b    = thr_b_r;
    assign classic_active = classic_r;
    assign sync_active    = sync_en_r;
    assign sync_pulse     = pulse_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [9:0] gap_r;
    logic       gap_vld_r;

    always_ff @(posedge clk)
    begin
        if (sys_rst || pulse_r || $changed(sync_divider))
            gap_r <= 10'd1;
        else if (gap_r != 10'h3ff)
            gap_r <= gap_r + 10'd1;
    end

    // The first pulse after a divider change ends a partial count, so only later gaps are measured.
    always_ff @(posedge clk)
    begin
        if (sys_rst || $changed(sync_divider))
            gap_vld_r <= 1'b0;
        else if (pulse_r)
            gap_vld_r <= 1'b1;
    end

    a_full_step_sel: assert property (@(posedge clk) disable iff (sys_rst) // see [RULE2]
        full_step_active |=> classic_r)
        else $error("full step did not force classic mode");
    a_offset_zero: assert property (@(posedge clk) disable iff (sys_rst) // see [RULE5]
        classic_r && hysteresis_end_field == `COCS_OFFSET_ZERO |=> thr_a_r == {1'b0, $past(target_mag_a)})
        else $error("offset code three did not give zero offset");
    a_sync_period: assert property (@(posedge clk) disable iff (sys_rst) // see [RULE10]
        pulse_r && gap_vld_r && $stable(sync_divider) && sync_divider != 4'h0 && gap_r != 10'd1
            |-> gap_r == {sync_divider, 6'd0})
        else $error("sync period is not divider times 64");
    a_sync_off: assert property (@(posedge clk) disable iff (sys_rst) // see [RULE10]
        sync_divider == 4'h0 |=> !pulse_r && !sync_en_r)
        else $error("sync active with divider zero");
    a_sync_upper_velocity_limit: assert property (@(posedge clk) disable iff (sys_rst) // see [RULE11]
        velocity > upper_velocity_limit |=> !sync_en_r)
        else $error("sync not suspended above velocity limit");
    a_sync_quiet: assert property (@(posedge clk) disable iff (sys_rst) // see [RULE12]
        quiet_mode_active |=> !sync_en_r)
        else $error("sync active in quiet mode");
    a_rnd_off: assert property (@(posedge clk) disable iff (sys_rst) // see [RULE8]
        !random_off_en |=> rnd_a_r == 4'h0 && rnd_b_r == 4'h0)
        else $error("random addend present while disabled");
endmodule : cocs_top

// ==== tb/cocs_stage_model.sv ====
// Behavioural power stage and current comparators for both coils.
`timescale 1ns/1ps
module cocs_stage_model
    import cocs_pkg::*;
(
    input  wire logic       clk,
    input  cocs_phase_e     phase_a,
    input  cocs_phase_e     phase_b,
    input  wire logic [9:0] on_delay,
    input  wire logic [9:0] fd_delay,
    output logic            cur_reached_a,
    output logic            cur_reached_b,
    output logic            fd_cmp_a,
    output logic            fd_cmp_b
);
    // ------------------------------------------------------------
    // Phase age counters
    // ------------------------------------------------------------
    logic [9:0]  age_a  = 10'h0;
    logic [9:0]  age_b  = 10'h0;
    cocs_phase_e last_a = PH_IDLE;
    cocs_phase_e last_b = PH_IDLE;

    always @(posedge clk)
    begin
        last_a <= phase_a;
        last_b <= phase_b;
        age_a  <= (phase_a == last_a) ? age_a + 10'h1 : 10'h0;
        age_b  <= (phase_b == last_b) ? age_b + 10'h1 : 10'h0;
    end

    // Current climbs during the on phase; the comparator trips after on_delay cycles.
    // In the first cycle of a phase the age of the phase just left still stands, so the last
    // phase must agree as well, or the comparator would trip at once.
    assign cur_reached_a = (phase_a == PH_ON) && (last_a == PH_ON) && (age_a >= on_delay);
    assign cur_reached_b = (phase_b == PH_ON) && (last_b == PH_ON) && (age_b >= on_delay);
    // A zero fd_delay means the negative current never overtakes the last positive peak.
    assign fd_cmp_a = (phase_a == PH_FAST) && (last_a == PH_FAST) && (fd_delay != 10'h0)
                      && (age_a >= fd_delay);
    assign fd_cmp_b = (phase_b == PH_FAST) && (last_b == PH_FAST) && (fd_delay != 10'h0)
                      && (age_b >= fd_delay);
endmodule : cocs_stage_model

// ==== tb/cocs_top_tb_top.sv ====
// Self-checking bench for the two-coil chopper timing block.
`timescale 1ns/1ps
module cocs_top_tb_top
    import cocs_pkg::*;
;
    localparam int CEIL = 20000;
    logic        clk = 1'b0;
    logic        sys_rst, chopper_mode, fast_decay_msb, fd_cmp_disable, random_off_en;
    logic        full_step_active, quiet_mode_active, pulse_q, spread;
    logic [2:0]  hysteresis_start_field;
    logic [3:0]  hysteresis_end_field, slow_decay_time, sync_divider;
    logic [19:0] velocity, upper_velocity_limit;
    logic [7:0]  target_mag_a, target_mag_b;
    logic        cur_reached_a, cur_reached_b, fd_cmp_a, fd_cmp_b;
    logic [8:0]  threshold_a, threshold_b;
    logic        classic_active, sync_active, sync_pulse;
    logic [9:0]  on_delay, fd_delay;
    cocs_phase_e phase_a, phase_b, prev_ph;
    int          n_fail = 0;
    int          compares = 0;
    int          cycles = 0;
    int          len, i;
    int          fd_tab [2] = '{1, 9};

    always #20 clk = ~clk;

    cocs_top DUT (.clk, .sys_rst, .chopper_mode, .fast_decay_msb, .hysteresis_start_field,
                  .hysteresis_end_field, .slow_decay_time, .fd_cmp_disable, .random_off_en,
                  .sync_divider, .velocity, .upper_velocity_limit, .full_step_active,
                  .quiet_mode_active, .target_mag_a, .target_mag_b, .cur_reached_a,
                  .cur_reached_b, .fd_cmp_a, .fd_cmp_b, .phase_a, .phase_b, .threshold_a,
                  .threshold_b, .classic_active, .sync_active, .sync_pulse);

    cocs_stage_model stage (.clk, .phase_a, .phase_b, .on_delay, .fd_delay, .cur_reached_a,
                            .cur_reached_b, .fd_cmp_a, .fd_cmp_b);

    // ------------------------------------------------------------
    // Monitor and hang guard
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        prev_ph <= phase_a;
        pulse_q <= sync_pulse;
        cycles  <= cycles + 1;
        if (cycles == CEIL)
        begin
            n_fail++;
            end_of_test();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    // Returns on the first cycle of a fresh entry into ph, so lengths are never partial.
    task automatic wait_ph(input cocs_phase_e ph);
        int t;
        t = 0;
        while (phase_a == ph && t < 4000)
        begin
            tick(1);
            t++;
        end
        while (phase_a != ph && t < 4000)
        begin
            tick(1);
            t++;
        end
    endtask : wait_ph

    task automatic phase_len(input cocs_phase_e ph, output int n);
        wait_ph(ph);
        n = 0;
        while (phase_a == ph && n < 4000)
        begin
            tick(1);
            n++;
        end
    endtask : phase_len

    task automatic end_of_test();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        sys_rst = 1'b1;
        chopper_mode = 1'b1;
        fast_decay_msb = 1'b0;
        hysteresis_start_field = 3'h2;
        hysteresis_end_field = 4'h3;
        slow_decay_time = 4'h2;
        fd_cmp_disable = 1'b1;
        random_off_en = 1'b0;
        sync_divider = 4'h0;
        velocity = 20'h00010;
        upper_velocity_limit = 20'h00100;
        full_step_active = 1'b0;
        quiet_mode_active = 1'b0;
        target_mag_a = 8'h64;
        target_mag_b = 8'h50;
        on_delay = 10'h00a;
        fd_delay = 10'h014;
        tick(2);
        check("rst_phase_a", phase_a, PH_IDLE);
        check("rst_thr_a", threshold_a, 0);
        check("rst_sync", {classic_active, sync_active, sync_pulse}, 0);
        sys_rst = 1'b0;
        tick(3);
        check("classic_mode1", classic_active, 1);
        for (i = 0; i < 16; i++)
        begin
            hysteresis_end_field = 4'(i);
            tick(3);
            check("thr_a", threshold_a, 100 + i - 3);
            check("thr_b", threshold_b, 80 + i - 3);
        end
        target_mag_a = 8'h01;
        hysteresis_end_field = 4'h0;
        tick(3);
        check("thr_clamp", threshold_a, 0);
        chopper_mode = 1'b0;
        tick(3);
        check("classic_mode0", classic_active, 0);
        check("thr_hyst", threshold_a, 1);
        full_step_active = 1'b1;
        tick(3);
        check("classic_forced", classic_active, 1);
        full_step_active = 1'b0;
        chopper_mode = 1'b1;
        hysteresis_end_field = 4'h3;
        for (i = 0; i < 2; i++)
        begin
            {fast_decay_msb, hysteresis_start_field} = 4'(fd_tab[i]);
            phase_len(PH_FAST, len);
            phase_len(PH_FAST, len);
            check("fast_len", len, fd_tab[i] * 32);
        end
        phase_len(PH_SLOW, len);
        check("slow_len", len, 24 + 32 * 2);
        {fast_decay_msb, hysteresis_start_field} = 4'h0;
        wait_ph(PH_SLOW);
        wait_ph(PH_SLOW);
        check("fast_skipped", prev_ph, PH_ON);
        {fast_decay_msb, hysteresis_start_field} = 4'hf;
        fd_cmp_disable = 1'b0;
        phase_len(PH_FAST, len);
        phase_len(PH_FAST, len);
        check("fast_cut", (len < 480) && (len >= 20), 1);
        fd_cmp_disable = 1'b1;
        hysteresis_start_field = 3'h2;
        fast_decay_msb = 1'b0;
        random_off_en = 1'b1;
        spread = 1'b0;
        for (i = 0; i < 6; i++)
        begin
            phase_len(PH_SLOW, len);
            check("rnd_range", (len >= 88) && (len <= 103), 1);
            if (len != 88)
                spread = 1'b1;
        end
        check("rnd_varies", spread, 1);
        random_off_en = 1'b0;
        sync_divider = 4'h4;
        tick(3);
        check("sync_on", sync_active, 1);
        i = 0;
        while (sync_pulse !== 1'b1 && i < 2000)
        begin
            tick(1);
            i++;
        end
        len = 0;
        do
        begin
            tick(1);
            len++;
        end while (sync_pulse !== 1'b1 && len < 2000);
        check("sync_period", len, 4 * 64);
        phase_len(PH_SLOW, len);
        check("sync_slow_len", len, 88);
        wait_ph(PH_WAIT);
        wait_ph(PH_ON);
        check("wait_exit", {prev_ph == PH_WAIT, pulse_q}, 2'h3);
        velocity = 20'h00200;
        tick(3);
        check("sync_fast_vel", sync_active, 0);
        wait_ph(PH_ON);
        check("no_wait_vel", prev_ph, PH_SLOW);
        velocity = 20'h00010;
        quiet_mode_active = 1'b1;
        tick(3);
        check("sync_quiet", sync_active, 0);
        quiet_mode_active = 1'b0;
        sync_divider = 4'h0;
        tick(3);
        check("sync_off", sync_active, 0);
        spread = 1'b0;
        for (i = 0; i < 300; i++)
        begin
            tick(1);
            if (sync_pulse !== 1'b0)
                spread = 1'b1;
        end
        check("no_pulse", spread, 0);
        wait_ph(PH_ON);
        check("free_run", prev_ph, PH_SLOW);
        check("coil_b_run", phase_b != PH_IDLE, 1);
        slow_decay_time = 4'h0;
        tick(4);
        check("drv_off", {phase_a, phase_b}, {PH_IDLE, PH_IDLE});
        end_of_test();
    end
endmodule : cocs_top_tb_top
